// [logic/xip_cache_control_status.sv]
// Control, status and lookup logic of the execute-in-place read cache.
// Functional notes
// - Sleep bit powers down memories, contents kept.
// - Writing sleep one forces cache enable off.
// - SRAM-mode access while asleep returns bus error.
// - Non-allocating alias writes fault or drop silently.
// - Allocating alias write invalidates matching tag entry unless asleep.
// - Cache disabled: every non-SRAM read goes to flash.
// - Enabled: valid tag hit skips flash access for alias_sel values 0 and 1.
// - Enabled: SRAM-mode access errors, data untouched.
// - Trigger write clears tags, keeps data memory.
// - SRAM contents survive tag clear and reset.
// - Trigger register read stalls until clear finishes.
// - Done bit low during clear, else high.
// - Block reset starts an automatic tag clear.
// - Streaming FIFO holds exactly two words.
// - Full flag high exactly at two entries.
// - Empty flag high at zero entries, resets high.
`timescale 1ns/10ps
`default_nettype none

module xip_cache_control_status #(
  parameter int LINES = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire xip_cache_pkg::xip_req_t xip_req,
  output xip_cache_pkg::xip_rsp_t xip_rsp,
  output xip_cache_pkg::flash_req_t flash_req,
  input wire logic flash_ack,
  input wire logic [31:0] flash_rdata,
  input wire logic stream_push,
  input wire logic stream_pop,
  output logic irq
);

  localparam int IDX_W = $clog2(LINES);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(LINES - 1);
  localparam int LVL_W = $clog2(xip_cache_pkg::STREAM_DEPTH + 1);
  localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(xip_cache_pkg::STREAM_DEPTH);
  localparam logic [LVL_W-1:0] LVL_EMPTY = '0;

  function automatic logic [IDX_W-1:0] line_of(input logic [31:0] a);
    line_of = a[IDX_W+1:2];
  endfunction

  // ==========================================================================
  // Register state
  logic cache_on_reg;
  logic bad_alias_reg;
  logic cache_sleep_reg;
  logic trigger_reg;
  logic clear_busy_reg;
  logic [IDX_W-1:0] clear_idx_reg;
  logic [LVL_W-1:0] stream_level_reg;
  logic [xip_cache_pkg::IRQ_W-1:0] irq_status_reg;
  logic [xip_cache_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [xip_cache_pkg::IRQ_W-1:0] irq_event;
  logic [31:0] rd_value;
  logic wr_fire;
  logic rd_stall;
  logic clear_finish;

  // Tag and valid arrays are deliberately not reset: the walker clears valid
  // bits, and the data array must keep SRAM contents across reset.
  logic [29:0] tag_mem [LINES];
  logic valid_mem [LINES];
  logic [31:0] data_mem [LINES];

  xip_cache_pkg::xip_state_t state_reg;

  assign wr_fire = avs_write && !avs_waitrequest;
  assign clear_finish = clear_busy_reg && !trigger_reg && (clear_idx_reg == LAST_IDX);
  // A pending trigger counts as an ongoing clear, so no early release is possible.
  assign rd_stall = (avs_address == xip_cache_pkg::TAG_CLEAR_TRIGGER_OFS) &&
                    (clear_busy_reg || trigger_reg);

  // ==========================================================================
  // Read mux
  always_comb
  begin
    rd_value = 32'h0;
    unique case (avs_address)
      xip_cache_pkg::CACHE_CONTROL_OFS:
      begin
        rd_value[xip_cache_pkg::CTRL_CACHE_ON_BIT] = cache_on_reg;
        rd_value[xip_cache_pkg::CTRL_BAD_ALIAS_BIT] = bad_alias_reg;
        rd_value[xip_cache_pkg::CTRL_CACHE_SLEEP_BIT] = cache_sleep_reg;
      end
      xip_cache_pkg::TAG_CLEAR_TRIGGER_OFS:
      begin
        rd_value[xip_cache_pkg::TRIGGER_BIT] = trigger_reg;
      end
      xip_cache_pkg::CACHE_STATUS_OFS:
      begin
        rd_value[xip_cache_pkg::STAT_DONE_BIT] = !clear_busy_reg;
        rd_value[xip_cache_pkg::STAT_EMPTY_BIT] = (stream_level_reg == LVL_EMPTY);
        rd_value[xip_cache_pkg::STAT_FULL_BIT] = (stream_level_reg == LVL_FULL);
      end
      xip_cache_pkg::IRQ_STATUS_OFS:
      begin
        rd_value[xip_cache_pkg::IRQ_W-1:0] = irq_status_reg;
      end
      xip_cache_pkg::IRQ_MASK_OFS:
      begin
        rd_value[xip_cache_pkg::IRQ_W-1:0] = irq_mask_reg;
      end
      default:
      begin
        rd_value = 32'h0;
      end
    endcase
  end

  // ==========================================================================
  // Avalon-MM handshake
  // Every access gets exactly one low cycle of waitrequest; the extra idle
  // cycle between accesses trades throughput for a purely registered output.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      avs_response <= 2'h0;
    end
    else if (avs_waitrequest && (avs_write || (avs_read && !rd_stall)))
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? rd_value : 32'h0;
      avs_response <= 2'h0;
    end
    else
    begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ==========================================================================
  // Control register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cache_on_reg <= xip_cache_pkg::CACHE_ON_RESET;
      bad_alias_reg <= xip_cache_pkg::BAD_ALIAS_RESET;
      cache_sleep_reg <= xip_cache_pkg::CACHE_SLEEP_RESET;
    end
    else if (wr_fire && avs_byteenable[0] &&
             avs_address == xip_cache_pkg::CACHE_CONTROL_OFS)
    begin
      bad_alias_reg <= avs_writedata[xip_cache_pkg::CTRL_BAD_ALIAS_BIT];
      cache_sleep_reg <= avs_writedata[xip_cache_pkg::CTRL_CACHE_SLEEP_BIT];
      cache_on_reg <= avs_writedata[xip_cache_pkg::CTRL_CACHE_ON_BIT] &&
                      !avs_writedata[xip_cache_pkg::CTRL_CACHE_SLEEP_BIT];
    end
  end

  // ==========================================================================
  // Tag clear trigger and walker
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      trigger_reg <= 1'b0;
    end
    else if (wr_fire && avs_byteenable[0] &&
             avs_address == xip_cache_pkg::TAG_CLEAR_TRIGGER_OFS &&
             avs_writedata[xip_cache_pkg::TRIGGER_BIT])
    begin
      trigger_reg <= 1'b1;
    end
    else
    begin
      trigger_reg <= 1'b0;
    end
  end

  // A trigger during a running clear restarts the walk from line zero.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      clear_busy_reg <= 1'b1;
      clear_idx_reg <= '0;
    end
    else if (trigger_reg)
    begin
      clear_busy_reg <= 1'b1;
      clear_idx_reg <= '0;
    end
    else if (clear_busy_reg)
    begin
      clear_idx_reg <= clear_idx_reg + IDX_W'(1);
      if (clear_finish)
      begin
        clear_busy_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Streaming FIFO level
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stream_level_reg <= LVL_EMPTY;
    end
    else
    begin
      unique case ({stream_push && stream_level_reg != LVL_FULL,
                    stream_pop && stream_level_reg != LVL_EMPTY})
        2'b10: stream_level_reg <= stream_level_reg + LVL_W'(1);
        2'b01: stream_level_reg <= stream_level_reg - LVL_W'(1);
        default: stream_level_reg <= stream_level_reg;
      endcase
    end
  end

  // ==========================================================================
  // XIP access engine
  logic take;
  logic [IDX_W-1:0] req_line;
  logic tag_hit;

  assign take = (state_reg == xip_cache_pkg::ST_IDLE) && xip_req.valid && !clear_busy_reg;
  assign req_line = line_of(xip_req.addr);
  assign tag_hit = valid_mem[req_line] && (tag_mem[req_line] == xip_req.addr[31:2]);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= xip_cache_pkg::ST_IDLE;
      xip_rsp <= '0;
      flash_req <= '0;
      irq_event <= '0;
    end
    else
    begin
      irq_event <= '0;
      unique case (state_reg)
        xip_cache_pkg::ST_IDLE:
        begin
          if (take)
          begin
            state_reg <= xip_cache_pkg::ST_RESP;
            xip_rsp.ready <= 1'b1;
            xip_rsp.error <= 1'b0;
            xip_rsp.rdata <= 32'h0;
            if (xip_req.sram)
            begin
              if (cache_sleep_reg || cache_on_reg)
              begin
                xip_rsp.error <= 1'b1;
                irq_event[xip_cache_pkg::IRQ_SRAM_ERROR_BIT] <= 1'b1;
              end
              else if (!xip_req.write)
              begin
                xip_rsp.rdata <= data_mem[req_line];
              end
            end
            else if (xip_req.write)
            begin
              if (xip_req.alias_sel != xip_cache_pkg::ALIAS_CACHE_ALLOC && bad_alias_reg)
              begin
                xip_rsp.error <= 1'b1;
                irq_event[xip_cache_pkg::IRQ_ALIAS_FAULT_BIT] <= 1'b1;
              end
            end
            else if (cache_on_reg && !xip_req.alias_sel[1] && tag_hit)
            begin
              xip_rsp.rdata <= data_mem[req_line];
            end
            else
            begin
              state_reg <= xip_cache_pkg::ST_FLASH;
              xip_rsp.ready <= 1'b0;
              flash_req.valid <= 1'b1;
              flash_req.addr <= xip_req.addr;
            end
          end
        end
        xip_cache_pkg::ST_FLASH:
        begin
          if (flash_ack)
          begin
            flash_req.valid <= 1'b0;
            xip_rsp.ready <= 1'b1;
            xip_rsp.error <= 1'b0;
            xip_rsp.rdata <= flash_rdata;
            state_reg <= xip_cache_pkg::ST_RESP;
          end
        end
        xip_cache_pkg::ST_RESP:
        begin
          xip_rsp.ready <= 1'b0;
          xip_rsp.error <= 1'b0;
          state_reg <= xip_cache_pkg::ST_IDLE;
        end
      endcase
      if (clear_finish)
      begin
        irq_event[xip_cache_pkg::IRQ_CLEAR_DONE_BIT] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Cache memories
  // The request is held stable while in the flash state, so its line and
  // address can be reused for the fill.
  always_ff @(posedge clk)
  begin
    if (clear_busy_reg && !trigger_reg)
    begin
      valid_mem[clear_idx_reg] <= 1'b0;
    end
    else if (take && xip_req.sram && xip_req.write && !cache_sleep_reg && !cache_on_reg)
    begin
      data_mem[req_line] <= xip_req.wdata;
    end
    else if (take && !xip_req.sram && xip_req.write &&
             xip_req.alias_sel == xip_cache_pkg::ALIAS_CACHE_ALLOC && tag_hit &&
             !cache_sleep_reg)
    begin
      valid_mem[req_line] <= 1'b0;
    end
    else if (state_reg == xip_cache_pkg::ST_FLASH && flash_ack && cache_on_reg &&
             xip_req.alias_sel == xip_cache_pkg::ALIAS_CACHE_ALLOC)
    begin
      valid_mem[req_line] <= 1'b1;
      tag_mem[req_line] <= xip_req.addr[31:2];
      data_mem[req_line] <= flash_rdata;
    end
  end

  // ==========================================================================
  // Interrupts
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_status_reg <= '0;
      irq_mask_reg <= xip_cache_pkg::IRQ_MASK_RESET;
      irq <= 1'b0;
    end
    else
    begin
      // New events win over a simultaneous write-one-to-clear.
      if (wr_fire && avs_byteenable[0] && avs_address == xip_cache_pkg::IRQ_STATUS_OFS)
      begin
        irq_status_reg <= (irq_status_reg & ~avs_writedata[xip_cache_pkg::IRQ_W-1:0]) |
                          irq_event;
      end
      else
      begin
        irq_status_reg <= irq_status_reg | irq_event;
      end
      if (wr_fire && avs_byteenable[0] && avs_address == xip_cache_pkg::IRQ_MASK_OFS)
      begin
        irq_mask_reg <= avs_writedata[xip_cache_pkg::IRQ_W-1:0];
      end
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

endmodule

`default_nettype wire

// [include/xip_cache_pkg.sv]
// Package with register map, field layout, reset values and carriers of the XIP cache controller.
package xip_cache_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] CACHE_CONTROL_OFS = 8'h00;
  localparam logic [7:0] TAG_CLEAR_TRIGGER_OFS = 8'h04;
  localparam logic [7:0] CACHE_STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h24;

  // ==========================================================================
  // Field positions
  localparam int CTRL_CACHE_ON_BIT = 0;
  localparam int CTRL_BAD_ALIAS_BIT = 1;
  localparam int CTRL_CACHE_SLEEP_BIT = 3;
  localparam int TRIGGER_BIT = 0;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_EMPTY_BIT = 1;
  localparam int STAT_FULL_BIT = 2;
  localparam int IRQ_CLEAR_DONE_BIT = 0;
  localparam int IRQ_ALIAS_FAULT_BIT = 1;
  localparam int IRQ_SRAM_ERROR_BIT = 2;
  localparam int IRQ_W = 3;

  // ==========================================================================
  // Reset values
  localparam logic CACHE_ON_RESET = 1'b1;
  localparam logic BAD_ALIAS_RESET = 1'b1;
  localparam logic CACHE_SLEEP_RESET = 1'b0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  // ==========================================================================
  // Address aliases and stream FIFO
  localparam logic [1:0] ALIAS_CACHE_ALLOC = 2'h0;
  localparam int STREAM_DEPTH = 2;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic write;
    logic sram;
    logic [1:0] alias_sel;
    logic [31:0] addr;
    logic [31:0] wdata;
  } xip_req_t;

  typedef struct packed {
    logic ready;
    logic error;
    logic [31:0] rdata;
  } xip_rsp_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } flash_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FLASH = 3'b010,
    ST_RESP = 3'b100
  } xip_state_t;

endpackage

// [verification/flash_model.sv]
// Behavioural serial flash that answers word reads with an address-derived pattern.
`timescale 1ns/10ps
`default_nettype none

module flash_model (
  input wire logic clk,
  input wire xip_cache_pkg::flash_req_t flash_req,
  output logic flash_ack,
  output logic [31:0] flash_rdata
);
  logic slow = 1'b0;
  int wait_cnt = 0;

  initial
  begin
    flash_ack = 1'b0;
    flash_rdata = 32'h0000_0000;
  end

  // Answers alternate between prompt and slow so both fill paths get exercised.
  // Outside the ack cycle the data lines flip every cycle, so a late sample cannot pass.
  always @(posedge clk)
  begin
    flash_ack <= 1'b0;
    flash_rdata <= ~flash_rdata;
    if (flash_req.valid && !flash_ack)
    begin
      if (wait_cnt == (slow ? 6 : 1))
      begin
        flash_ack <= 1'b1;
        flash_rdata <= ~flash_req.addr;
        slow <= !slow;
        wait_cnt <= 0;
      end
      else
        wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

`default_nettype wire

// [verification/xip_cache_checker.sv]
// Port-level assertions for the XIP cache control and status block.
`timescale 1ns/10ps
`default_nettype none

module xip_cache_checker #(
  parameter int LINES = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire xip_cache_pkg::xip_req_t xip_req,
  input wire xip_cache_pkg::xip_rsp_t xip_rsp,
  input wire xip_cache_pkg::flash_req_t flash_req,
  input wire logic flash_ack,
  input wire logic [31:0] flash_rdata,
  input wire logic stream_push,
  input wire logic stream_pop
);
  localparam int MAXW = LINES + 8;
  logic [1:0] level_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Reference fill level of the stream FIFO
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      level_reg <= 2'h0;
    else if (stream_push && level_reg != 2'h2 && !(stream_pop && level_reg != 2'h0))
      level_reg <= level_reg + 2'h1;
    else if (stream_pop && level_reg != 2'h0 && !(stream_push && level_reg != 2'h2))
      level_reg <= level_reg - 2'h1;
  end

  // ==========================================================================
  // Properties
  sequence fill_end;
    flash_req.valid && flash_ack;
  endsequence

  sequence answer_back;
    xip_rsp.ready && !flash_req.valid && xip_rsp.rdata == $past(flash_rdata);
  endsequence

  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  resp_okay_a: assert property (!avs_waitrequest |-> avs_response == 2'h0)
    else $error("bus response not okay");
  trig_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 8'h04
    |-> avs_readdata[0] == 1'b0) else $error("trigger bit read back as one");
  // The read data was captured one edge before waitrequest is seen low, so the
  // reference level of that earlier edge is the one to compare against.
  stat_flags_a: assert property (avs_read && !avs_waitrequest && avs_address == 8'h08
    |-> avs_readdata[2:1] == {$past(level_reg) == 2'h2, $past(level_reg) == 2'h0})
    else $error("stream flags disagree with fill level");
  read_bound_a: assert property ($rose(avs_read) |-> ##[1:MAXW] !avs_waitrequest)
    else $error("read stalled beyond the tag clear time");
  flash_hold_a: assert property (flash_req.valid && !flash_ack
    |=> flash_req.valid && $stable(flash_req.addr)) else $error("flash request dropped early");
  fill_return_a: assert property (fill_end |=> answer_back)
    else $error("flash word not returned on the next cycle");
  no_flash_write_a: assert property ($rose(flash_req.valid)
    |-> $past(xip_req.valid) && !$past(xip_req.write) && !$past(xip_req.sram))
    else $error("flash read started by a write or an SRAM access");
  rdy_pulse_a: assert property (xip_rsp.ready |=> !xip_rsp.ready)
    else $error("xip ready held longer than one cycle");
endmodule

bind xip_cache_control_status xip_cache_checker #(.LINES(LINES)) chk (
  .clk, .rst_n, .avs_address, .avs_read, .avs_readdata, .avs_waitrequest,
  .avs_response, .xip_req, .xip_rsp, .flash_req, .flash_ack, .flash_rdata,
  .stream_push, .stream_pop
);

`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the XIP cache control and status block.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  localparam int LINES = 4;
  localparam logic [31:0] ADDR_A = 32'h0000_0040;
  localparam logic [31:0] DATA_D = 32'h1234_5678;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  xip_cache_pkg::xip_req_t xip_req = '0;
  xip_cache_pkg::xip_rsp_t xip_rsp;
  xip_cache_pkg::flash_req_t flash_req;
  logic flash_ack;
  logic [31:0] flash_rdata;
  logic stream_push = 1'b0;
  logic stream_pop = 1'b0;
  logic irq;
  logic err;
  logic [31:0] rd;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int fills = 0;
  int f;

  xip_cache_control_status #(.LINES(LINES)) dut (.clk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .avs_response, .xip_req, .xip_rsp, .flash_req, .flash_ack, .flash_rdata,
    .stream_push, .stream_pop, .irq);
  flash_model fm (.clk, .flash_req, .flash_ack, .flash_rdata);

  always #4 clk = ~clk;

  // The ceiling sits far above the few hundred cycles the scenarios need.
  always @(posedge clk)
  begin
    cycles++;
    if (flash_req.valid === 1'b1 && flash_ack === 1'b1)
      fills++;
    if (cycles == 20000)
    begin
      bad_count++;
      summarize();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic xip(input logic w, s, input logic [1:0] al, input logic [31:0] a, d);
    xip_req <= '{1'b1, w, s, al, a, d};
    @(posedge clk);
    while (xip_rsp.ready !== 1'b1)
      @(posedge clk);
    rd = xip_rsp.rdata;
    err = xip_rsp.error;
    xip_req.valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pulse(input logic p, q);
    stream_push <= p;
    stream_pop <= q;
    @(posedge clk);
    stream_push <= 1'b0;
    stream_pop <= 1'b0;
    @(posedge clk);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_boot();
    bus(0, 8'h08, 32'h0);
    check("status_boot", 32'h2, rd);
    bus(0, 8'h00, 32'h0);
    check("control_reset", 32'h3, rd);
    bus(0, 8'h24, 32'h0);
    check("mask_reset", 32'h0, rd);
    bus(0, 8'h04, 32'h0);
    check("trigger_read", 32'h0, rd);
    bus(0, 8'h08, 32'h0);
    check("status_done", 32'h3, rd);
    bus(0, 8'h10, 32'h0);
    check("unmapped_read", 32'h0, rd);
  endtask

  task automatic t_cache();
    f = fills;
    xip(0, 0, 2'h0, ADDR_A, 32'h0);
    check("miss_data", ~ADDR_A, rd);
    xip(0, 0, 2'h0, ADDR_A, 32'h0);
    check("hit_data", ~ADDR_A, rd);
    check("hit_no_flash", f + 1, fills);
    xip(1, 0, 2'h0, ADDR_A, 32'h0);
    xip(0, 0, 2'h0, ADDR_A, 32'h0);
    check("refill_after_write", f + 2, fills);
    xip(0, 0, 2'h0, ADDR_A, 32'h0);
    bus(1, 8'h04, 32'h1);
    f = cycles;
    bus(0, 8'h04, 32'h0);
    check("read_stalls", 32'h1, {31'h0, (cycles - f) > LINES});
    check("trigger_self_clear", 32'h0, rd);
    f = fills;
    xip(0, 0, 2'h0, ADDR_A, 32'h0);
    check("refill_after_clear", f + 1, fills);
    bus(1, 8'h00, 32'h2);
    xip(0, 0, 2'h0, ADDR_A, 32'h0);
    xip(0, 0, 2'h0, ADDR_A, 32'h0);
    check("bypass_reads", f + 3, fills);
  endtask

  task automatic t_alias();
    bus(1, 8'h00, 32'h3);
    bus(1, 8'h20, 32'h7);
    xip(1, 0, 2'h2, ADDR_A, 32'h0);
    check("fault_error", 32'h1, {31'h0, err});
    bus(0, 8'h20, 32'h0);
    check("fault_status", 32'h2, rd);
    check("irq_masked", 32'h0, {31'h0, irq});
    bus(1, 8'h24, 32'h2);
    repeat (2) @(posedge clk);
    check("irq_raised", 32'h1, {31'h0, irq});
    bus(1, 8'h20, 32'h2);
    repeat (2) @(posedge clk);
    check("irq_cleared", 32'h0, {31'h0, irq});
    bus(1, 8'h00, 32'h1);
    xip(1, 0, 2'h2, ADDR_A, 32'h0);
    check("write_dropped", 32'h0, {31'h0, err});
  endtask

  task automatic t_sram();
    bus(1, 8'h00, 32'h0);
    xip(1, 1, 2'h0, ADDR_A, DATA_D);
    check("sram_write_ok", 32'h0, {31'h0, err});
    bus(1, 8'h00, 32'h1);
    xip(1, 1, 2'h0, ADDR_A, ~DATA_D);
    check("sram_on_error", 32'h1, {31'h0, err});
    bus(0, 8'h20, 32'h0);
    check("sram_err_status", 32'h4, rd);
    bus(1, 8'h00, 32'h9);
    bus(0, 8'h00, 32'h0);
    check("sleep_forces_off", 32'h8, rd);
    xip(0, 1, 2'h0, ADDR_A, 32'h0);
    check("sram_sleep_error", 32'h1, {31'h0, err});
    bus(1, 8'h04, 32'h1);
    do_reset();
    bus(1, 8'h00, 32'h0);
    xip(0, 1, 2'h0, ADDR_A, 32'h0);
    check("sram_kept", DATA_D, rd);
    bus(0, 8'h20, 32'h0);
    check("clear_done_irq", 32'h1, rd);
  endtask

  task automatic t_stream();
    pulse(1, 0);
    bus(0, 8'h08, 32'h0);
    check("one_entry", 32'h1, rd);
    pulse(1, 0);
    pulse(1, 0);
    bus(0, 8'h08, 32'h0);
    check("two_full", 32'h5, rd);
    pulse(1, 1);
    bus(0, 8'h08, 32'h0);
    check("push_pop_full", 32'h1, rd);
    pulse(0, 1);
    pulse(0, 1);
    bus(0, 8'h08, 32'h0);
    check("drained", 32'h3, rd);
  endtask

  initial
  begin
    do_reset();
    t_boot();
    t_cache();
    t_alias();
    t_sram();
    t_stream();
    summarize();
  end
endmodule

`default_nettype wire
